/* core/clock_timer_pkg.sv */
// Purpose: shared constants and types for the clock timer tick accumulator
// Assumes: 32-bit register port, one 10 MHz clock
// Notes: offsets are byte addresses on the register port
package clock_timer_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_FLAG = 32'hFFFFE700;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 32'hFFFFE704;
  localparam logic [ADDR_W-1:0] OFS_ACCUM = 32'hFFFFE708;

  // Control and flag register field positions
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_SEL_LSB = 1;
  localparam int unsigned CTRL_CLR_BIT = 3;
  localparam int unsigned CTRL_SPARE_LSB = 6;
  localparam int unsigned FLAG_BIT = 0;

  localparam logic [DATA_W-1:0] RESET_WORD = 32'h00000000;
  localparam logic CLR_READ_VALUE = 1'b1;
  localparam logic CLR_ACTIVE = 1'b0;

  // Timing: backup clock rate derived from the main clock
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned FS_HZ = 32_768;
  localparam int unsigned FS_DIV_DEF = CLK_HZ / FS_HZ;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned PRESC_W = 15;

  typedef struct packed {
    logic [1:0] spare;
    logic [1:0] sel;
    logic run;
  } ctrl_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  localparam ctrl_s CTRL_RESET = '{spare: 2'h0, sel: 2'h0, run: 1'b0};
endpackage

/* core/clock_timer_tick_accumulator.sv */
// Purpose: clock timer control, backup reset monitor and tick accumulator
// Assumes: sys_rst is the backup-domain reset; register port is word-only
// Notes: read data appear the cycle after the read strobe
//
// Overview of operation
// - Registers take full 32-bit transfers only
// - Reads undefined before backup reset seen
// - Accumulator-clear bit always reads as one
// - Monitor flag set by writing one only
// - Backup reset clears monitor flag to zero
// - 32-bit accumulator counts each tick
// - Holds 2^32 ticks before overflow; one second each at interval 00 only
// - Accumulator write loads value, clears prescaler
// - Other flag bits read-only; reset zero
// - Run zero stops and clears; one counts
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module clock_timer_tick_accumulator
  import clock_timer_pkg::*;
#(
  parameter logic [DIV_W-1:0] FS_DIV = DIV_W'(FS_DIV_DEF)
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire reg_req_s reg_req,
  output logic [DATA_W-1:0] rdata,
  output logic interval_tick_interrupt
);
  typedef struct packed {
    ctrl_s ctrl;
    logic flag;
    logic [DATA_W-1:0] rdata;
  } top_state_s;

  top_state_s state_r;
  top_state_s state_nxt;

  logic [DATA_W-1:0] accum_count;
  logic accum_wr;
  logic accum_clr;
  logic ctrl_wr;
  logic stop_wr;
  logic tick;

  // Whole-word port, no byte lanes exist to split a transfer
  assign ctrl_wr = reg_req.wr && (reg_req.addr == OFS_CTRL);
  assign accum_wr = reg_req.wr && (reg_req.addr == OFS_ACCUM);
  assign accum_clr = ctrl_wr && (reg_req.wdata[CTRL_CLR_BIT] == CLR_ACTIVE);
  // Stop acts at the write edge, so no tick slips out one cycle later
  assign stop_wr = ctrl_wr && !reg_req.wdata[CTRL_RUN_BIT];

  tick_prescaler #(
    .FS_DIV(FS_DIV)
  ) tick_prescaler_inst (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(state_r.ctrl.run),
    .restart(accum_wr || stop_wr),
    .sel(state_r.ctrl.sel),
    .tick(tick)
  );

  tick_accumulator tick_accumulator_inst (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load(accum_wr),
    .load_value(reg_req.wdata),
    .clear(accum_clr),
    .tick(tick),
    .count(accum_count)
  );

  always_comb begin
    logic [DATA_W-1:0] ctrl_word;
    ctrl_word = RESET_WORD;
    ctrl_word[CTRL_RUN_BIT] = state_r.ctrl.run;
    ctrl_word[CTRL_SEL_LSB +: 2] = state_r.ctrl.sel;
    ctrl_word[CTRL_CLR_BIT] = CLR_READ_VALUE;
    ctrl_word[CTRL_SPARE_LSB +: 2] = state_r.ctrl.spare;
    state_nxt = state_r;
    state_nxt.rdata = RESET_WORD;
    if (ctrl_wr) begin
      // Interval is taken as written; a change while running is software's hazard
      state_nxt.ctrl.run = reg_req.wdata[CTRL_RUN_BIT];
      state_nxt.ctrl.sel = reg_req.wdata[CTRL_SEL_LSB +: 2];
      state_nxt.ctrl.spare = reg_req.wdata[CTRL_SPARE_LSB +: 2];
    end
    if (reg_req.wr && (reg_req.addr == OFS_FLAG) && reg_req.wdata[FLAG_BIT]) begin
      state_nxt.flag = 1'b1;
    end
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        OFS_FLAG: state_nxt.rdata[FLAG_BIT] = state_r.flag;
        OFS_CTRL: state_nxt.rdata = ctrl_word;
        OFS_ACCUM: state_nxt.rdata = accum_count;
        default: state_nxt.rdata = RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= '{ctrl: CTRL_RESET, flag: 1'b0, rdata: RESET_WORD};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata = state_r.rdata;
  assign interval_tick_interrupt = tick;
endmodule
`default_nettype wire

/* core/tick_accumulator.sv */
// Purpose: 32-bit tick count accumulator
// Assumes: load and clear are single-cycle requests
// Notes: load beats clear beats increment
`timescale 1ns/100ps
`default_nettype none
module tick_accumulator
  import clock_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [DATA_W-1:0] load_value,
  input wire logic clear,
  input wire logic tick,
  output logic [DATA_W-1:0] count
);
  typedef struct packed {
    logic [DATA_W-1:0] count;
  } accum_state_s;

  accum_state_s state_r;
  accum_state_s state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (load) begin
      state_nxt.count = load_value;
    end else if (clear) begin
      state_nxt.count = RESET_WORD;
    end else if (tick) begin
      // Plain wrap keeps counting after all ones
      state_nxt.count = state_r.count + DATA_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= '{count: RESET_WORD};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign count = state_r.count;
endmodule
`default_nettype wire

/* core/tick_prescaler.sv */
// Purpose: backup clock enable and tick interval prescaler
// Assumes: run and restart are synchronous to mclk
// Notes: tick is a one-cycle pulse from a flip-flop
`timescale 1ns/100ps
`default_nettype none
module tick_prescaler
  import clock_timer_pkg::*;
#(
  parameter logic [DIV_W-1:0] FS_DIV = DIV_W'(FS_DIV_DEF)
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic restart,
  input wire logic [1:0] sel,
  output logic tick
);
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [PRESC_W-1:0] presc;
    logic tick;
  } presc_state_s;

  presc_state_s state_r;
  presc_state_s state_nxt;

  // Interval 00 is the longest, each step halves it
  function automatic logic [PRESC_W-1:0] last_count(input logic [1:0] s);
    last_count = PRESC_W'({PRESC_W{1'b1}} >> s);
  endfunction

  always_comb begin
    logic fs_en;
    fs_en = (state_r.div == FS_DIV - DIV_W'(1));
    state_nxt = state_r;
    state_nxt.tick = 1'b0;
    if (!run || restart) begin
      state_nxt.div = '0;
      state_nxt.presc = '0;
    end else begin
      state_nxt.div = fs_en ? '0 : state_r.div + DIV_W'(1);
      if (fs_en) begin
        if (state_r.presc >= last_count(sel)) begin
          state_nxt.presc = '0;
          state_nxt.tick = 1'b1;
        end else begin
          state_nxt.presc = state_r.presc + PRESC_W'(1);
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign tick = state_r.tick;
endmodule
`default_nettype wire

/* dv/clock_timer_tick_accumulator_test.sv */
// Purpose: register-level test of the tick accumulator
// Assumes: FS_DIV of 2, interval select 3, then select 2 for the slow-interval checks
// Notes: write strobe held until the next task call
`timescale 1ns/100ps
`default_nettype none
module clock_timer_tick_accumulator_test
  import clock_timer_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_s req = '0;
  logic [DATA_W-1:0] rdata;
  logic tick;
  int n_errors = 0;
  int comparisons = 0;
  clock_timer_tick_accumulator #(.FS_DIV(16'h0002)) clock_timer_tick_accumulator_inst (.mclk(mclk),
    .sys_rst(sys_rst), .reg_req(req), .rdata(rdata), .interval_tick_interrupt(tick));
  always #50 mclk = ~mclk;
  task automatic end_of_test();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge mclk);
      req.wr <= 1'b0;
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
  endtask
  task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge mclk);
    req.rd <= 1'b0;
    #1;
    comparisons++;
    if (rdata !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, rdata);
    end
  endtask
  task automatic wait_tick();
    int i;
    // Look just after the edge, once the tick flop has settled
    for (i = 0; i < 20000 && tick !== 1'b1; i++) begin
      cyc(1);
      #1;
    end
    if (tick !== 1'b1) begin
      n_errors++;
      $display("[FAIL] tick expected 1 seen %b", tick);
      end_of_test();
    end else begin
      cyc(3);
    end
  endtask
  initial begin
    cyc(2);
    sys_rst <= 1'b0;
    rd("flag", OFS_FLAG, 32'h00000000);
    rd("accum", OFS_ACCUM, 32'h00000000);
    rd("ctrl", OFS_CTRL, 32'h00000008);
    rd("unmapped", 32'hFFFFE70C, 32'h00000000);
    wr(OFS_FLAG, 32'h00000000);
    rd("flag zero write", OFS_FLAG, 32'h00000000);
    wr(OFS_FLAG, 32'hFFFFFFFF);
    rd("flag set", OFS_FLAG, 32'h00000001);
    $display("registers test done");
    wr(OFS_ACCUM, 32'hFFFFFFFF);
    rd("accum load", OFS_ACCUM, 32'hFFFFFFFF);
    wr(OFS_CTRL, 32'h0000000F);
    wait_tick();
    rd("accum wrap", OFS_ACCUM, 32'h00000000);
    wait_tick();
    rd("accum count", OFS_ACCUM, 32'h00000001);
    cyc(4000);
    wr(OFS_ACCUM, 32'h00000005);
    cyc(6000);
    rd("prescaler restart", OFS_ACCUM, 32'h00000005);
    wr(OFS_CTRL, 32'h00000007);
    rd("accum clear", OFS_ACCUM, 32'h00000000);
    rd("ctrl running", OFS_CTRL, 32'h0000000F);
    wr(OFS_CTRL, 32'hFFFFFF3E);
    rd("ctrl stopped", OFS_CTRL, 32'h0000000E);
    wr(OFS_ACCUM, 32'h00000003);
    cyc(9000);
    rd("stopped", OFS_ACCUM, 32'h00000003);
    wr(OFS_CTRL, 32'h0000000D);
    cyc(9000);
    rd("slow interval", OFS_ACCUM, 32'h00000003);
    wait_tick();
    rd("slow tick", OFS_ACCUM, 32'h00000004);
    $display("counting test done");
    @(posedge mclk);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    rd("flag after reset", OFS_FLAG, 32'h00000000);
    rd("accum after reset", OFS_ACCUM, 32'h00000000);
    $display("reset test done");
    end_of_test();
  end
endmodule
bind clock_timer_tick_accumulator tick_accum_monitor tick_accum_monitor_inst (.mclk(mclk), .sys_rst(sys_rst),
  .reg_req(reg_req), .rdata(rdata), .interval_tick_interrupt(interval_tick_interrupt));
`default_nettype wire

/* dv/tick_accum_monitor.sv */
// Purpose: port checks for the tick accumulator
// Assumes: single mclk domain
// Notes: bound from the testbench
`timescale 1ns/100ps
`default_nettype none
module tick_accum_monitor
  import clock_timer_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire reg_req_s reg_req,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic interval_tick_interrupt
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic tk, rd_f, rd_c, rd_a, wr_f, wr_c, wr_a;
  assign tk = interval_tick_interrupt;
  assign rd_f = reg_req.rd && reg_req.addr == OFS_FLAG;
  assign rd_c = reg_req.rd && reg_req.addr == OFS_CTRL;
  assign rd_a = reg_req.rd && reg_req.addr == OFS_ACCUM;
  assign wr_f = reg_req.wr && reg_req.addr == OFS_FLAG;
  assign wr_c = reg_req.wr && reg_req.addr == OFS_CTRL;
  assign wr_a = reg_req.wr && reg_req.addr == OFS_ACCUM;
  read_idle_zero_a: assert property (!$past(reg_req.rd) |-> rdata == RESET_WORD)
    else $error("rdata not zero outside read");
  flag_upper_ro_a: assert property (rd_f |=> rdata[31:1] == 31'h0)
    else $error("flag upper bits not zero");
  clr_reads_one_a: assert property (rd_c |=> rdata[CTRL_CLR_BIT] == CLR_READ_VALUE)
    else $error("clear bit read not one");
  flag_set_a: assert property (wr_f && reg_req.wdata[FLAG_BIT] ##1 rd_f |=> rdata[FLAG_BIT])
    else $error("flag not set by write");
  accum_load_a: assert property (wr_a && !tk ##1 rd_a && !tk |=> rdata == $past(reg_req.wdata, 2))
    else $error("accumulator load lost");
  load_restart_a: assert property (wr_a |=> !tk [*8])
    else $error("tick soon after accumulator write");
  stop_quiet_a: assert property (wr_c && !reg_req.wdata[CTRL_RUN_BIT] |=> !tk [*8])
    else $error("tick while stopped");
  tick_pulse_a: assert property (tk |=> !tk)
    else $error("tick longer than one cycle");
  cover property (tk);
  cover property (rd_a);
  cover property (wr_f);
endmodule
`default_nettype wire
